// ===== lilc_intr_line.sv
// board-level model of the open-drain interrupt line seen by the processor
// assumes an external pull-up; the block only ever pulls the line low
module lilc_intr_line (
   input wire logic PIN_O,
   input wire logic PIN_OE_N,
   output logic LINE
);
   // released line floats up to the pull-up level, never to the last value
   always_comb begin
      LINE = PIN_OE_N ? 1'b1 : PIN_O;
   end
endmodule

// ===== lilc_pkg.sv
// constants, register map and state layout for the regulator and input-limit control block
// assumes one 20 MHz clock shared by the register port and all control logic
package lilc_pkg;

   // register port
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [7:0] OFS_REG_CTRL = 8'h80;
   localparam logic [7:0] OFS_REG_VOLT = 8'h81;
   localparam logic [7:0] OFS_PROT = 8'h82;
   localparam logic [7:0] OFS_INT_FLAG = 8'h83;
   localparam logic [7:0] OFS_INT_MASK = 8'h84;
   localparam logic [7:0] OFS_RAIL_FLOOR = 8'h8F;
   localparam logic [7:0] OFS_INPUT_LIMIT = 8'h94;

   // register field positions
   localparam int BIT_ENABLE = 0;
   localparam int BIT_STBY_KEEP = 1;
   localparam int BIT_SLEEP_KEEP = 2;
   localparam int BIT_LOW_POWER = 3;
   localparam int BIT_PROTECT = 0;
   localparam int BIT_FAULT = 0;
   localparam int VCODE_LSB = 0;
   localparam int VCODE_W = 4;
   localparam int RAIL_LSB = 6;
   localparam int RAIL_W = 2;
   localparam int ILIM_LSB = 3;
   localparam int ILIM_W = 5;

   // power-on patterns
   localparam logic [5:0] RAIL_RSV_BITS = 6'h2B;
   localparam logic [7:0] RAIL_POR = 8'h2B;
   localparam logic [7:0] LIMIT_POR = 8'h68;
   localparam logic [3:0] VCODE_POR = 4'h0;

   // voltage and current encodings
   localparam logic [11:0] VOLT_BASE_MV = 12'h708;
   localparam logic [11:0] VOLT_STEP_MV = 12'h064;
   localparam logic [12:0] RAIL_MV_00 = 13'hDAC;
   localparam logic [12:0] RAIL_MV_01 = 13'hE74;
   localparam logic [12:0] RAIL_MV_10 = 13'h10CC;
   localparam logic [10:0] ILIM_BASE_MA = 11'h00A;
   localparam logic [10:0] ILIM_FINE_STEP_MA = 11'h005;
   localparam logic [10:0] ILIM_COARSE_STEP_MA = 11'h064;
   localparam logic [10:0] ILIM_COARSE_BASE_MA = 11'h12C;
   localparam logic [4:0] ILIM_FINE_LAST = 5'h08;
   localparam logic [4:0] ILIM_COARSE_FIRST = 5'h0C;
   localparam logic [4:0] ILIM_COARSE_LAST = 5'h13;
   localparam logic [4:0] ILIM_TOP_CODE = 5'h14;
   localparam logic [10:0] ILIM_TOP_MA = 11'h5DC;

   // power states from the sequencer
   localparam logic [1:0] PST_RUN = 2'h0;
   localparam logic [1:0] PST_STANDBY = 2'h1;
   localparam logic [1:0] PST_SLEEP = 2'h2;

   typedef enum logic [1:0] {
      PH_LOAD = 2'b01,
      PH_LIVE = 2'b10
   } lilc_phase_e;

   typedef struct packed {
      lilc_phase_e phase;
      logic en;
      logic stby_keep;
      logic sleep_keep;
      logic low_power;
      logic [3:0] vcode;
      logic protect;
      logic fault;
      logic mask;
      logic [1:0] rail;
      logic [4:0] ilim;
      logic reg_on;
      logic reg_lp;
      logic rail_rsv;
      logic ilim_rsv;
      logic [11:0] volt_mv;
      logic [12:0] rail_mv;
      logic [10:0] ilim_ma;
      logic int_oe_n;
      logic [7:0] rdata;
   } lilc_state_s;

   localparam lilc_state_s STATE_POR = '{
      phase: PH_LOAD, en: 1'b0, stby_keep: 1'b0, sleep_keep: 1'b0, low_power: 1'b0,
      vcode: VCODE_POR, protect: 1'b0, fault: 1'b0, mask: 1'b1,
      rail: RAIL_POR[7:6], ilim: LIMIT_POR[7:3], reg_on: 1'b0, reg_lp: 1'b0,
      rail_rsv: 1'b0, ilim_rsv: 1'b0,
      volt_mv: VOLT_BASE_MV, rail_mv: RAIL_MV_00, ilim_ma: ILIM_BASE_MA,
      int_oe_n: 1'b1, rdata: 8'h00};

endpackage

// ===== lilc_sync.sv
// two-stage synchroniser for levels arriving from outside the clock domain
// assumes the source holds each level for at least two clock periods
module lilc_sync
   import lilc_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [WIDTH-1:0] D,
   output logic [WIDTH-1:0] Q
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] q_ff;

   // first stage feeds only the second
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= D;
         q_ff <= meta_ff;
      end
   end

   assign Q = q_ff;

endmodule

// ===== lilc_top.sv
// regulator control, overcurrent fault handling and input front-end registers
// assumes a byte register port from the serial interface, same clock, strobed writes
module lilc_top
   import lilc_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [ADDR_W-1:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [DATA_W-1:0] REG_WDATA,
   output logic [DATA_W-1:0] REG_RDATA,
   input wire logic [1:0] PMIC_STATE,
   input wire logic [RAIL_W-1:0] OTP_RAIL_FLOOR,
   input wire logic OVERCURRENT,
   output logic REG_ON,
   output logic REG_LOW_POWER,
   output logic [VCODE_W-1:0] REG_VOLT_CODE,
   output logic [11:0] REG_VOLT_MV,
   output logic [12:0] RAIL_FLOOR_MV,
   output logic RAIL_FLOOR_RESERVED,
   output logic [10:0] INPUT_LIMIT_MA,
   output logic INPUT_LIMIT_RESERVED,
   output logic INTERRUPT_OUT_N_O,
   output logic INTERRUPT_OUT_N_OE_N
);

   lilc_state_s st_ff;
   lilc_state_s nxt_st;
   logic oc_sync;
   logic int_low_ff;

   // analog flag is asynchronous to this clock
   lilc_sync #(
      .WIDTH(1)
   ) u_oc_sync (
      .CLK(CLK),
      .RST_N(RST_N),
      .D(OVERCURRENT),
      .Q(oc_sync)
   );

   function automatic logic [10:0] ilim_decode(input logic [4:0] code);
      logic [10:0] ma;
      ma = 11'h000;
      if (code <= ILIM_FINE_LAST) begin
         ma = ILIM_BASE_MA + ILIM_FINE_STEP_MA * {6'h00, code};
      end else if (code < ILIM_COARSE_FIRST) begin
         ma = ILIM_COARSE_STEP_MA + ILIM_COARSE_STEP_MA * ({6'h00, code} - 11'h009) / 11'h002;
      end else if (code <= ILIM_COARSE_LAST) begin
         ma = ILIM_COARSE_BASE_MA + ILIM_COARSE_STEP_MA * ({6'h00, code} - 11'h00C);
      end else if (code == ILIM_TOP_CODE) begin
         ma = ILIM_TOP_MA;
      end
      return ma;
   endfunction

   logic wr_ctrl;
   logic wr_volt;
   logic wr_prot;
   logic wr_flag;
   logic wr_mask;
   logic wr_limit;
   logic keep;

   always_comb begin
      wr_ctrl = REG_WR && (REG_ADDR == OFS_REG_CTRL);
      wr_volt = REG_WR && (REG_ADDR == OFS_REG_VOLT);
      wr_prot = REG_WR && (REG_ADDR == OFS_PROT);
      wr_flag = REG_WR && (REG_ADDR == OFS_INT_FLAG);
      wr_mask = REG_WR && (REG_ADDR == OFS_INT_MASK);
      wr_limit = REG_WR && (REG_ADDR == OFS_INPUT_LIMIT);
      nxt_st = st_ff;

      case (st_ff.phase)
         PH_LOAD: begin
            // rail floor is taken from OTP once, after reset release
            nxt_st.rail = OTP_RAIL_FLOOR;
            nxt_st.phase = PH_LIVE;
         end
         PH_LIVE: begin
            nxt_st.phase = PH_LIVE;
         end
         default: begin
            nxt_st.phase = PH_LOAD;
         end
      endcase

      if (wr_ctrl) begin
         nxt_st.en = REG_WDATA[BIT_ENABLE];
         nxt_st.stby_keep = REG_WDATA[BIT_STBY_KEEP];
         nxt_st.sleep_keep = REG_WDATA[BIT_SLEEP_KEEP];
         nxt_st.low_power = REG_WDATA[BIT_LOW_POWER];
      end
      if (wr_volt) begin
         nxt_st.vcode = REG_WDATA[VCODE_LSB +: VCODE_W];
      end
      if (wr_prot) begin
         nxt_st.protect = REG_WDATA[BIT_PROTECT];
      end
      if (wr_mask) begin
         nxt_st.mask = REG_WDATA[BIT_FAULT];
      end
      if (wr_limit) begin
         nxt_st.ilim = REG_WDATA[ILIM_LSB +: ILIM_W];
      end
      if (wr_flag && REG_WDATA[BIT_FAULT]) begin
         nxt_st.fault = 1'b0;
      end

      // hardware wins over a same-cycle software write, so no event is lost
      if (oc_sync) begin
         nxt_st.fault = 1'b1;
         if (st_ff.protect) begin
            nxt_st.en = 1'b0;
         end
         // protection off: enable keeps its value, analog stays in current limit
      end

      case (PMIC_STATE)
         PST_RUN: keep = 1'b1;
         PST_STANDBY: keep = st_ff.stby_keep;
         PST_SLEEP: keep = st_ff.sleep_keep;
         default: keep = 1'b0;
      endcase
      nxt_st.reg_on = st_ff.en && keep;
      nxt_st.reg_lp = st_ff.en && keep && (PMIC_STATE != PST_RUN) && st_ff.low_power;

      nxt_st.volt_mv = VOLT_BASE_MV + VOLT_STEP_MV * {8'h00, st_ff.vcode};

      case (st_ff.rail)
         2'h0: nxt_st.rail_mv = RAIL_MV_00;
         2'h1: nxt_st.rail_mv = RAIL_MV_01;
         2'h2: nxt_st.rail_mv = RAIL_MV_10;
         default: nxt_st.rail_mv = RAIL_MV_10; // reserved code parks at the safest floor
      endcase
      nxt_st.rail_rsv = (st_ff.rail == 2'h3);

      nxt_st.ilim_ma = ilim_decode(st_ff.ilim);
      nxt_st.ilim_rsv = (st_ff.ilim > ILIM_TOP_CODE);

      // pin pulled low only by an unmasked flag; masked flag still reads back
      nxt_st.int_oe_n = !(st_ff.fault && !st_ff.mask);

      case (REG_ADDR)
         OFS_REG_CTRL: nxt_st.rdata = {4'h0, st_ff.low_power, st_ff.sleep_keep,
                                       st_ff.stby_keep, st_ff.en};
         OFS_REG_VOLT: nxt_st.rdata = {4'h0, st_ff.vcode};
         OFS_PROT: nxt_st.rdata = {7'h00, st_ff.protect};
         OFS_INT_FLAG: nxt_st.rdata = {7'h00, st_ff.fault};
         OFS_INT_MASK: nxt_st.rdata = {7'h00, st_ff.mask};
         OFS_RAIL_FLOOR: nxt_st.rdata = {st_ff.rail, RAIL_RSV_BITS};
         OFS_INPUT_LIMIT: nxt_st.rdata = {st_ff.ilim, 3'h0};
         default: nxt_st.rdata = 8'h00;
      endcase
   end

   // reset pattern sets the mask and clears protection
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_ff <= STATE_POR;
         int_low_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         int_low_ff <= 1'b0;
      end
   end

   always_comb begin
      REG_RDATA = st_ff.rdata;
      REG_ON = st_ff.reg_on;
      REG_LOW_POWER = st_ff.reg_lp;
      REG_VOLT_CODE = st_ff.vcode;
      REG_VOLT_MV = st_ff.volt_mv;
      RAIL_FLOOR_MV = st_ff.rail_mv;
      RAIL_FLOOR_RESERVED = st_ff.rail_rsv;
      INPUT_LIMIT_MA = st_ff.ilim_ma;
      INPUT_LIMIT_RESERVED = st_ff.ilim_rsv;
      INTERRUPT_OUT_N_O = int_low_ff;
      INTERRUPT_OUT_N_OE_N = st_ff.int_oe_n;
   end

   volt_decode_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      st_ff.phase == PH_LIVE |=> st_ff.volt_mv == 1800 + 100 * $past(st_ff.vcode))
   else $error("voltage decode wrong");

   run_on_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (PMIC_STATE == PST_RUN && st_ff.en) |=> st_ff.reg_on)
   else $error("regulator not on in run");

   stby_off_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (PMIC_STATE == PST_STANDBY && !st_ff.stby_keep) |=> !st_ff.reg_on)
   else $error("regulator on in standby without keep");

   low_power_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (PMIC_STATE == PST_SLEEP && st_ff.en && st_ff.sleep_keep)
      |=> st_ff.reg_on && (st_ff.reg_lp == $past(st_ff.low_power)))
   else $error("low-power selection wrong in sleep");

   protect_off_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (oc_sync && st_ff.protect) |=> !st_ff.en && st_ff.fault ##1 !st_ff.reg_on)
   else $error("protection did not disable regulator");

   no_protect_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (oc_sync && !st_ff.protect && !wr_ctrl) |=> st_ff.en == $past(st_ff.en))
   else $error("enable changed without protection");

   fault_set_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      $rose(OVERCURRENT) ##2 oc_sync |=> st_ff.fault)
   else $error("overload did not set fault flag");

   mask_hold_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      st_ff.mask [*2] |-> st_ff.int_oe_n)
   else $error("masked fault drove interrupt pin");

   clear_flag_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (wr_flag && REG_WDATA[BIT_FAULT] && !oc_sync) |=> !st_ff.fault ##1 st_ff.int_oe_n)
   else $error("write-one clear failed");

   limit_top_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (st_ff.ilim == 5'h14) |=> INPUT_LIMIT_MA == 1500)
   else $error("top input limit decode wrong");

   rail_load_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (st_ff.phase == PH_LOAD) |=> st_ff.rail == $past(OTP_RAIL_FLOOR))
   else $error("rail floor not taken from OTP");

   rail_fixed_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (st_ff.phase == PH_LIVE) |=> $stable(st_ff.rail))
   else $error("rail floor changed after load");

   rail_rsv_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (st_ff.rail == 2'h3) |=> RAIL_FLOOR_RESERVED && RAIL_FLOOR_MV == RAIL_MV_10)
   else $error("reserved rail code not flagged");

   int_pull_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (st_ff.fault && !st_ff.mask) |=> !INTERRUPT_OUT_N_OE_N)
   else $error("unmasked fault did not pull interrupt pin");

   flag_sticky_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (st_ff.fault && !(wr_flag && REG_WDATA[BIT_FAULT])) |=> st_ff.fault)
   else $error("fault flag dropped without a clear");

   oc_flag_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      oc_sync |=> st_ff.fault)
   else $error("synchronised overload did not set flag");

   limit_write_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      wr_limit |=> st_ff.ilim == $past(REG_WDATA[7:3]))
   else $error("input limit write lost");

   limit_read_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (REG_ADDR == OFS_INPUT_LIMIT) |=> REG_RDATA == {$past(st_ff.ilim), 3'h0})
   else $error("input limit readback wrong");

   limit_rsv_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (st_ff.ilim > ILIM_TOP_CODE) |=> INPUT_LIMIT_RESERVED && INPUT_LIMIT_MA == 11'h000)
   else $error("reserved input limit not flagged");

   volt_write_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      wr_volt |=> REG_VOLT_CODE == $past(REG_WDATA[3:0]))
   else $error("voltage code write lost");

   run_full_a:
   assert property (@(posedge CLK) disable iff (!RST_N)
      (PMIC_STATE == PST_RUN) |=> !REG_LOW_POWER)
   else $error("low-power mode in run state");

endmodule

// ===== testbench.sv
// self-checking bench: register port tasks, power-state table, overcurrent cases
// assumes one 20 MHz clock and the interrupt line model beside the block
module testbench
   import lilc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, wr, oc, reg_on, reg_lp, rail_rsv, lim_rsv, int_o, int_oe_n, int_line;
   logic exp_on;
   logic [7:0] addr, wdata, rdata, rv;
   logic [1:0] pst, otp;
   logic [3:0] vcode;
   logic [11:0] volt_mv;
   logic [12:0] rail_mv;
   logic [10:0] lim_ma;
   int mismatches, compares, i;

   lilc_top i_lilc_top (.CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WR(wr),
      .REG_WDATA(wdata), .REG_RDATA(rdata), .PMIC_STATE(pst), .OTP_RAIL_FLOOR(otp),
      .OVERCURRENT(oc), .REG_ON(reg_on), .REG_LOW_POWER(reg_lp), .REG_VOLT_CODE(vcode),
      .REG_VOLT_MV(volt_mv), .RAIL_FLOOR_MV(rail_mv), .RAIL_FLOOR_RESERVED(rail_rsv),
      .INPUT_LIMIT_MA(lim_ma), .INPUT_LIMIT_RESERVED(lim_rsv),
      .INTERRUPT_OUT_N_O(int_o), .INTERRUPT_OUT_N_OE_N(int_oe_n));
   lilc_intr_line i_lilc_intr_line (.PIN_O(int_o), .PIN_OE_N(int_oe_n), .LINE(int_line));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic summarize;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      chk_out({8'h00, got}, {8'h00, exp});
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #5;
      addr = a;
      wdata = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
   endtask

   // read data is registered: it shows the address sampled one edge earlier
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #5;
      addr = a;
      tick(1);
      d = rdata;
   endtask

   task automatic oc_pulse;
      oc = 1'b1;
      tick(4);
      oc = 1'b0;
      tick(4);
   endtask

   function automatic logic [15:0] lim_exp(input int c);
      if (c <= 8) return 16'(10 + 5 * c);
      if (c <= 11) return 16'(50 * (c - 7));
      if (c <= 19) return 16'(300 + 100 * (c - 12));
      if (c == 20) return 16'h05DC;
      return 16'h0000;
   endfunction

   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      summarize();
   end

   initial begin
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      pst = 2'h0;
      otp = 2'h2;
      oc = 1'b0;
      repeat (2) @(posedge clk);
      #5;
      rst_n = 1'b1;
      tick(3);
      rd_reg(OFS_RAIL_FLOOR, rv);
      chk_reg(rv, 8'hAB);
      chk_out(16'(rail_mv), 16'h10CC);
      chk_out(16'(rail_rsv), 16'h0000);
      wr_reg(OFS_RAIL_FLOOR, 8'h00);
      rd_reg(OFS_RAIL_FLOOR, rv);
      chk_reg(rv, 8'hAB);
      rd_reg(OFS_INPUT_LIMIT, rv);
      chk_reg(rv, 8'h68);
      chk_out(16'(lim_ma), 16'h0190);
      rd_reg(OFS_PROT, rv);
      chk_reg(rv, 8'h00);
      rd_reg(OFS_INT_MASK, rv);
      chk_reg(rv, 8'h01);
      chk_out(16'(int_line), 16'h0001);
      wr_reg(8'h90, 8'hFF);
      rd_reg(8'h90, rv);
      chk_reg(rv, 8'h00);
      // reserved low bits written as ones must read back as zero
      for (i = 0; i < 32; i++) begin
         wr_reg(OFS_INPUT_LIMIT, {i[4:0], 3'h7});
         rd_reg(OFS_INPUT_LIMIT, rv);
         chk_reg(rv, {i[4:0], 3'h0});
         chk_out(16'(lim_ma), lim_exp(i));
         chk_out(16'(lim_rsv), 16'(i > 20));
      end
      for (i = 0; i < 16; i++) begin
         wr_reg(OFS_REG_VOLT, {4'h0, i[3:0]});
         tick(2);
         chk_out(16'(volt_mv), 16'(1800 + 100 * i));
         chk_out(16'(vcode), 16'(i));
      end
      for (i = 0; i < 64; i++) begin
         wr_reg(OFS_REG_CTRL, {4'h0, i[3:0]});
         pst = i[5:4];
         tick(2);
         exp_on = i[0] && (i[5:4] == 2'h0 || (i[5:4] == 2'h1 && i[1])
            || (i[5:4] == 2'h2 && i[2]));
         chk_out(16'(reg_on), 16'(exp_on));
         chk_out(16'(reg_lp), 16'(exp_on && i[5:4] != 2'h0 && i[3]));
      end
      pst = 2'h0;
      wr_reg(OFS_REG_CTRL, 8'h01);
      wr_reg(OFS_INT_MASK, 8'h00);
      oc_pulse();
      rd_reg(OFS_INT_FLAG, rv);
      chk_reg(rv, 8'h01);
      rd_reg(OFS_REG_CTRL, rv);
      chk_reg(rv, 8'h01);
      chk_out(16'(reg_on), 16'h0001);
      chk_out(16'(int_line), 16'h0000);
      wr_reg(OFS_INT_FLAG, 8'h01);
      tick(2);
      chk_out(16'(int_line), 16'h0001);
      rd_reg(OFS_INT_FLAG, rv);
      chk_reg(rv, 8'h00);
      wr_reg(OFS_PROT, 8'h01);
      oc_pulse();
      rd_reg(OFS_REG_CTRL, rv);
      chk_reg(rv, 8'h00);
      chk_out(16'(reg_on), 16'h0000);
      rd_reg(OFS_INT_FLAG, rv);
      chk_reg(rv, 8'h01);
      wr_reg(OFS_INT_MASK, 8'h01);
      tick(2);
      chk_out(16'(int_line), 16'h0001);
      rd_reg(OFS_INT_FLAG, rv);
      chk_reg(rv, 8'h01);
      // a flag already pending must pull the line as soon as it is unmasked
      wr_reg(OFS_INT_MASK, 8'h00);
      tick(2);
      chk_out(16'(int_line), 16'h0000);
      wr_reg(OFS_INT_FLAG, 8'h01);
      tick(2);
      chk_out(16'(int_line), 16'h0001);
      // pending unmasked fault, then a mid-run reset with each OTP floor code
      wr_reg(OFS_INT_MASK, 8'h00);
      oc_pulse();
      chk_out(16'(int_line), 16'h0000);
      for (i = 0; i < 4; i++) begin
         rst_n = 1'b0;
         otp = i[1:0];
         tick(2);
         rst_n = 1'b1;
         tick(3);
         chk_out(16'(int_line), 16'h0001);
         rd_reg(OFS_RAIL_FLOOR, rv);
         chk_reg(rv, {i[1:0], 6'h2B});
         chk_out(16'(rail_mv), (i == 0) ? 16'h0DAC : (i == 1) ? 16'h0E74 : 16'h10CC);
         chk_out(16'(rail_rsv), 16'(i == 3));
         rd_reg(OFS_PROT, rv);
         chk_reg(rv, 8'h00);
         rd_reg(OFS_INT_MASK, rv);
         chk_reg(rv, 8'h01);
      end
      summarize();
   end
endmodule
